// file: sfs_front_end.sv
// Serial flash link front end: frames commands, decodes opcodes, steers pins.
// Assumes the host drives chip select and serial clock; all pins are sampled by clk.
//
// Operation
// - Link uses select, clock, data in, out
// - Dual program: output pin becomes second input
// - Dual read: input pin becomes second output
// - Modes 0 and 3 both work
// - Sample on rising, drive on falling
// - All bytes shift most significant bit first
// - Select release ends the current command
// - Unknown opcode: ignore until next select
// - Truncated header: do nothing, return idle
// - Upper four address bits are ignored
// - Select release floats the output pin
`timescale 1ns/1ps
module sfs_front_end (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic bidir_in_out_pin_in,
   output logic bidir_in_out_pin_out,
   output logic bidir_in_out_pin_oe,
   input wire logic bidir_out_in_pin_in,
   output logic bidir_out_in_pin_out,
   output logic bidir_out_in_pin_oe,
   output sfs_pkg::sfs_word_t rec_data,
   output logic rec_valid,
   input wire logic rec_ready,
   input wire logic [sfs_pkg::BYTE_W-1:0] rd_data,
   input wire logic rd_valid,
   output logic rd_ready,
   output logic overrun
);
   import sfs_pkg::*;

   typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} sfs_state_t;

   // ---------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic sck_prev;

   // Two stages for every pin, the link clock included
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= 4'hf;
         pin_sync <= 4'hf;
         sck_prev <= 1'b0;
      end else begin
         pin_meta <= {cs_n, sck, bidir_in_out_pin_in, bidir_out_in_pin_in};
         pin_sync <= pin_meta;
         sck_prev <= pin_sync[2];
      end
   end

   // Edges count only inside a frame, so the idle level of either mode is harmless
   wire cs_act = !pin_sync[3];
   wire sck_s = pin_sync[2];
   wire si_s = pin_sync[1];
   wire so_s = pin_sync[0];
   wire rise = cs_act && sck_s && !sck_prev;
   wire fall = cs_act && !sck_s && sck_prev;

   // ---------------------------------------------
   // Frame state
   // ---------------------------------------------
   sfs_state_t state, next_state;
   sfs_io_t io, next_io;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [1:0] byte_cnt, next_byte_cnt;
   logic [1:0] dummy, next_dummy;
   logic [BYTE_W-1:0] rx_sh, next_rx_sh;
   logic [BYTE_W-1:0] opcode, next_opcode;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [BYTE_W-1:0] tx_sh, next_tx_sh;
   logic [BYTE_W-1:0] tx_hold;
   logic tx_have;
   logic emit;
   logic emit_cmd;
   logic tx_load;
   sfs_word_t pend_word;
   logic pend_valid;
   logic buf_in_ready;

   // ---------------------------------------------
   // Decode of the shift path
   // ---------------------------------------------
   wire dual_in = (state == ST_DATA) && (io == IO_RX2);
   wire [BYTE_W-1:0] rx_shift = dual_in ? {rx_sh[5:0], so_s, si_s} : {rx_sh[6:0], si_s};
   // Dual read also packs a byte into four clocks, or the reload would come one byte late
   wire dual_data = (state == ST_DATA) && (io == IO_RX2 || io == IO_TX2);
   wire [2:0] last_bit = dual_data ? LAST_BIT_DUAL : LAST_BIT_SINGLE;
   wire byte_done = rise && (bit_cnt == last_bit);
   wire sfs_dec_t dec = sfs_decode(rx_shift);
   wire [ADDR_W-1:0] addr_full = {addr[15:0], rx_shift};
   wire tx_mode = (io == IO_TX1) || (io == IO_TX2);

   // Command framing and opcode decode
   always_comb begin
      next_state = state;
      next_io = io;
      next_bit_cnt = bit_cnt;
      next_byte_cnt = byte_cnt;
      next_dummy = dummy;
      next_rx_sh = rx_sh;
      next_opcode = opcode;
      next_addr = addr;
      emit = 1'b0;
      emit_cmd = 1'b0;
      tx_load = 1'b0;
      if (!cs_act) begin
         // Release aborts any header; a command without address then reports zero
         next_state = ST_OPC;
         next_io = IO_NONE;
         next_bit_cnt = '0;
         next_byte_cnt = '0;
         next_addr = '0;
      end else if (rise) begin
         next_rx_sh = rx_shift;
         next_bit_cnt = byte_done ? 3'h0 : bit_cnt + 3'h1;
         unique case (state)
            ST_OPC: begin
               if (byte_done) begin
                  next_opcode = rx_shift;
                  next_dummy = dec.dummy;
                  next_io = dec.io;
                  if (!dec.ok) begin
                     next_state = ST_IGNORE;
                     next_io = IO_NONE;
                  end else if (dec.has_addr) begin
                     next_state = ST_ADDR;
                  end else begin
                     next_state = ST_DATA;
                     emit_cmd = 1'b1;
                     tx_load = (dec.io == IO_TX1) || (dec.io == IO_TX2);
                  end
               end
            end
            ST_ADDR: begin
               if (byte_done) begin
                  next_addr = addr_full;
                  next_byte_cnt = byte_cnt + 2'h1;
                  if (byte_cnt == LAST_ADDR_BYTE) begin
                     next_byte_cnt = '0;
                     next_state = (dummy != 2'h0) ? ST_DUMMY : ST_DATA;
                     emit_cmd = (dummy == 2'h0);
                     tx_load = (dummy == 2'h0) && tx_mode;
                  end
               end
            end
            ST_DUMMY: begin
               if (byte_done) begin
                  next_byte_cnt = byte_cnt + 2'h1;
                  if (byte_cnt == dummy - 2'h1) begin
                     next_state = ST_DATA;
                     emit_cmd = 1'b1;
                     tx_load = tx_mode;
                  end
               end
            end
            ST_DATA: begin
               emit = byte_done && (io == IO_RX1 || io == IO_RX2);
               tx_load = byte_done && tx_mode;
            end
            ST_IGNORE: next_rx_sh = rx_sh;
         endcase
      end
   end

   // Registered frame state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_OPC;
         io <= IO_NONE;
         bit_cnt <= '0;
         byte_cnt <= '0;
         dummy <= '0;
         rx_sh <= '0;
         opcode <= '0;
         addr <= '0;
      end else begin
         state <= next_state;
         io <= next_io;
         bit_cnt <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         dummy <= next_dummy;
         rx_sh <= next_rx_sh;
         opcode <= next_opcode;
         addr <= next_addr;
      end
   end

   // ---------------------------------------------
   // Record hand-off toward the user
   // ---------------------------------------------
   // Header record carries only the location bits; the top nibble is dropped
   wire [LOC_W-1:0] cmd_addr = (state == ST_ADDR) ? addr_full[LOC_W-1:0] : addr[LOC_W-1:0];
   wire sfs_word_t new_word = '{is_cmd: emit_cmd, opcode: (state == ST_OPC) ? rx_shift : opcode,
                                addr: cmd_addr, data: rx_shift};
   wire pend_take = pend_valid && buf_in_ready;

   // One pending slot; a full buffer stalls the hand-off, a second word then overruns
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_valid <= 1'b0;
         pend_word <= '0;
         overrun <= 1'b0;
      end else begin
         if (emit || emit_cmd) begin
            pend_valid <= 1'b1;
            pend_word <= new_word;
            if (pend_valid && !buf_in_ready) overrun <= 1'b1;
         end else if (pend_take) begin
            pend_valid <= 1'b0;
         end
      end
   end

   sfs_buf2 #(.WIDTH($bits(sfs_word_t)), .DEPTH(BUF_DEPTH)) u_buf (
      .clk(clk),
      .rst_n(rst_n),
      .in_data(pend_word),
      .in_valid(pend_valid),
      .in_ready(buf_in_ready),
      .out_data(rec_data),
      .out_valid(rec_valid),
      .out_ready(rec_ready)
   );

   // ---------------------------------------------
   // Read data path and pin drive
   // ---------------------------------------------
   wire rd_take = rd_valid && rd_ready;
   wire tx_dual = (io == IO_TX2);

   // Prefetch one byte; an empty slot sends all ones rather than stall the host
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_have <= 1'b0;
         tx_hold <= '0;
         rd_ready <= 1'b0;
      end else begin
         if (!cs_act) tx_have <= 1'b0;
         else if (rd_take) tx_have <= 1'b1;
         else if (tx_load) tx_have <= 1'b0;
         if (rd_take) tx_hold <= rd_data;
         rd_ready <= cs_act && tx_mode && !tx_have && !rd_take;
      end
   end

   // Falling edges shift out, two bits at a time in dual read
   always_comb begin
      next_tx_sh = tx_sh;
      if (tx_load) next_tx_sh = tx_have ? tx_hold : TX_FILL;
      else if (fall && state == ST_DATA) next_tx_sh = tx_dual ? {tx_sh[5:0], 2'b00} : {tx_sh[6:0], 1'b0};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh <= '0;
         bidir_out_in_pin_out <= 1'b0;
         bidir_in_out_pin_out <= 1'b0;
         bidir_out_in_pin_oe <= 1'b0;
         bidir_in_out_pin_oe <= 1'b0;
      end else begin
         tx_sh <= next_tx_sh;
         if (fall && state == ST_DATA && tx_mode) begin
            bidir_out_in_pin_out <= tx_sh[7];
            bidir_in_out_pin_out <= tx_dual ? tx_sh[6] : 1'b0;
         end
         bidir_out_in_pin_oe <= cs_act && state == ST_DATA && tx_mode;
         bidir_in_out_pin_oe <= cs_act && state == ST_DATA && tx_dual;
      end
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_cs_drop;
      cs_act ##1 !cs_act;
   endsequence

   chk_release_float: assert property (s_cs_drop |=> !bidir_out_in_pin_oe && !bidir_in_out_pin_oe)
      else $error("output still driven after select release");
   chk_release_idle: assert property (s_cs_drop |-> next_state == ST_OPC ##1 state == ST_OPC)
      else $error("command not ended by select release");
   chk_count_clear: assert property (!cs_act |=> bit_cnt == 3'h0 && byte_cnt == 2'h0)
      else $error("counters not cleared outside a frame");
   chk_trunc_none: assert property (state inside {ST_OPC, ST_ADDR, ST_DUMMY} && !cs_act |-> !emit && !emit_cmd)
      else $error("record issued for truncated header");
   chk_ignore_hold: assert property (state == ST_IGNORE && cs_act |=> state == ST_IGNORE && !$past(emit))
      else $error("ignored frame left or produced data");
   chk_dual_out: assert property (bidir_in_out_pin_oe |-> $past(io) == IO_TX2 && bidir_out_in_pin_oe)
      else $error("input pin driven outside dual read");
   chk_dual_in: assert property (io == IO_RX2 ##1 io == IO_RX2 |-> !bidir_out_in_pin_oe)
      else $error("output pin driven during dual program");
   chk_out_on_fall: assert property ($changed(bidir_out_in_pin_out) |-> $past(fall))
      else $error("output changed off a falling edge");
   chk_msb_first: assert property (rise && state == ST_OPC |=> rx_sh[0] == $past(si_s) && rx_sh[7:1] == $past(rx_sh[6:0]))
      else $error("opcode not shifted msb first");
   chk_addr_mask: assert property (emit_cmd && state == ST_ADDR |=> pend_word.addr == $past(addr_full[LOC_W-1:0]))
      else $error("record address not the low location bits");
endmodule

// file: sfs_pkg.sv
// Shared types and constants of the serial flash link front end.
// Assumes a single 100 MHz core clock; the serial clock is sampled, not used as a clock.
package sfs_pkg;

   // ---------------------------------------------
   // Widths and counts
   // ---------------------------------------------
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 24;
   localparam int LOC_W = 20;
   localparam int BUF_DEPTH = 2;
   localparam logic [2:0] LAST_BIT_SINGLE = 3'h7;
   localparam logic [2:0] LAST_BIT_DUAL = 3'h3;
   localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
   localparam logic [7:0] TX_FILL = 8'hff;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SYNC_STAGES = 2;

   // ---------------------------------------------
   // Opcodes
   // ---------------------------------------------
   localparam logic [7:0] OP_RD_FAST2 = 8'h1b;
   localparam logic [7:0] OP_RD_FAST = 8'h0b;
   localparam logic [7:0] OP_RD_SLOW = 8'h03;
   localparam logic [7:0] OP_RD_DUAL = 8'h3b;
   localparam logic [7:0] OP_ERASE4 = 8'h20;
   localparam logic [7:0] OP_ERASE32 = 8'h52;
   localparam logic [7:0] OP_ERASE64 = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE2 = 8'hc7;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_PROG_DUAL = 8'ha2;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDIS = 8'h04;
   localparam logic [7:0] OP_PROT = 8'h36;
   localparam logic [7:0] OP_UNPROT = 8'h39;
   localparam logic [7:0] OP_PROT_RD = 8'h3c;
   localparam logic [7:0] OP_LOCK = 8'h33;
   localparam logic [7:0] OP_LOCK_FRZ = 8'h34;
   localparam logic [7:0] OP_LOCK_RD = 8'h35;
   localparam logic [7:0] OP_OTP_PROG = 8'h9b;
   localparam logic [7:0] OP_OTP_RD = 8'h77;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR1 = 8'h01;
   localparam logic [7:0] OP_STAT_WR2 = 8'h31;
   localparam logic [7:0] OP_RESET = 8'hf0;
   localparam logic [7:0] OP_ID_RD = 8'h9f;
   localparam logic [7:0] OP_PDOWN = 8'hb9;
   localparam logic [7:0] OP_RESUME = 8'hab;

   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef enum logic [2:0] {IO_NONE, IO_RX1, IO_RX2, IO_TX1, IO_TX2} sfs_io_t;

   typedef struct packed {
      logic ok;
      logic has_addr;
      logic [1:0] dummy;
      sfs_io_t io;
   } sfs_dec_t;

   // One record toward the user: a command header or a received data byte
   typedef struct packed {
      logic is_cmd;
      logic [BYTE_W-1:0] opcode;
      logic [LOC_W-1:0] addr;
      logic [BYTE_W-1:0] data;
   } sfs_word_t;

   // Opcode table: address, dummy bytes and data direction
   function automatic sfs_dec_t sfs_decode(input logic [7:0] op);
      sfs_dec_t d;
      d = '{ok: 1'b1, has_addr: 1'b1, dummy: 2'h0, io: IO_NONE};
      case (op)
         OP_RD_FAST2, OP_OTP_RD: begin
            d.dummy = 2'h2;
            d.io = IO_TX1;
         end
         OP_RD_FAST: begin
            d.dummy = 2'h1;
            d.io = IO_TX1;
         end
         OP_RD_DUAL: begin
            d.dummy = 2'h1;
            d.io = IO_TX2;
         end
         OP_RD_SLOW, OP_PROT_RD, OP_LOCK_RD: d.io = IO_TX1;
         OP_PROG, OP_LOCK, OP_LOCK_FRZ, OP_OTP_PROG: d.io = IO_RX1;
         OP_PROG_DUAL: d.io = IO_RX2;
         OP_ERASE4, OP_ERASE32, OP_ERASE64, OP_PROT, OP_UNPROT: d.io = IO_NONE;
         OP_CHIP_ERASE, OP_CHIP_ERASE2, OP_WREN, OP_WRDIS, OP_PDOWN, OP_RESUME: d.has_addr = 1'b0;
         OP_STAT_RD, OP_ID_RD: begin
            d.has_addr = 1'b0;
            d.io = IO_TX1;
         end
         OP_STAT_WR1, OP_STAT_WR2, OP_RESET: begin
            d.has_addr = 1'b0;
            d.io = IO_RX1;
         end
         default: d.ok = 1'b0;
      endcase
      return d;
   endfunction

endpackage

// file: sfs_buf2.sv
// Small valid/ready buffer placed in the record path of the front end.
// Assumes both sides run on the same clock; depth is a power of two.
`timescale 1ns/1ps
module sfs_buf2 #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;

   // ---------------------------------------------
   // Handshake decode
   // ---------------------------------------------
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   // Storage and pointers; read side may stall and fill the buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   // Data words need no reset
   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr] <= in_data;
   end

   chk_buf_bound: assert property (@(posedge clk) disable iff (!rst_n) count <= (PW+1)'(DEPTH))
      else $error("buffer count beyond depth");
endmodule

// file: sfs_host_model.sv
// Behavioural link host that drives select and serial clock toward the front end.
// Assumes the bench joins its pin levels to the front end; it resolves the shared data wires itself.
`timescale 1ns/1ps
module sfs_host_model (
   output logic cs_n,
   output logic sck,
   output logic io0,
   output logic io1,
   input wire logic dev_out0,
   input wire logic dev_oe0,
   input wire logic dev_out1,
   input wire logic dev_oe1
);
   localparam realtime HALF = 62.5;
   logic h_oe0, h_oe1, h_d0, h_d1, flt, saw_oe0;

   // -----------------------------------------
   // Wire levels
   // -----------------------------------------
   // Released wires toggle, so a stale level can never pass for data
   always #7 flt = ~flt;
   assign io0 = dev_oe0 ? dev_out0 : (h_oe0 ? h_d0 : flt);
   assign io1 = dev_oe1 ? dev_out1 : (h_oe1 ? h_d1 : flt);

   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      {h_oe0, h_oe1, h_d0, h_d1, flt, saw_oe0} = 6'h00;
   end

   // -----------------------------------------
   // Frame tasks
   // -----------------------------------------
   // Clock idles at the mode's level before select falls
   task automatic begin_frame(input bit m3);
      sck = m3;
      saw_oe0 = 1'b0;
      #100 cs_n = 1'b0;
      #100;
   endtask

   // Drive on the fall, sample on the rise; dual 1 writes pairs, dual 2 reads pairs
   task automatic xfer(input logic [7:0] b, input int dual, input int nb, output logic [7:0] r);
      r = 8'h00;
      if (dual == 0) begin
         for (int i = 7; i > 7 - nb; i--) begin
            sck = 1'b0;
            h_oe0 = 1'b1;
            h_d0 = b[i];
            #HALF sck = 1'b1;
            r[i] = io1;
            saw_oe0 |= dev_oe0;
            #HALF;
         end
      end else begin
         for (int k = 0; k < 4; k++) begin
            sck = 1'b0;
            h_oe0 = (dual == 1);
            h_oe1 = (dual == 1);
            h_d1 = b[7-2*k];
            h_d0 = b[6-2*k];
            #HALF sck = 1'b1;
            r[7-2*k] = io1;
            r[6-2*k] = io0;
            saw_oe0 |= dev_oe0;
            #HALF;
         end
      end
   endtask

   // Mode 0 returns the clock low before select rises
   task automatic end_frame(input bit m3);
      if (!m3) begin
         sck = 1'b0;
         #HALF;
      end
      cs_n = 1'b1;
      h_oe0 = 1'b0;
      h_oe1 = 1'b0;
   endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the front end: random and corner frames through a host model.
// Assumes the host model above and the package constants; records are drained with random stalls.
`timescale 1ns/1ps
module tb_top;
   import sfs_pkg::*;
   logic clk = 0, rst_n = 0, rec_ready = 0, rd_valid = 0, stall = 0;
   logic [7:0] rd_data = 8'h00;
   logic cs_n, sck, io0, io1, o0, e0, o1, e1, rd_ready, rec_valid, overrun;
   sfs_word_t rec_data;
   sfs_word_t got_q[$], exp_q[$];
   logic [7:0] acc_q[$];
   integer seed = 60009;
   int n_mismatch = 0, samples_checked = 0, cyc = 0;

   always #5 clk = ~clk;

   sfs_front_end u_dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .bidir_in_out_pin_in(io0),
      .bidir_in_out_pin_out(o0), .bidir_in_out_pin_oe(e0), .bidir_out_in_pin_in(io1),
      .bidir_out_in_pin_out(o1), .bidir_out_in_pin_oe(e1), .rec_data(rec_data), .rec_valid(rec_valid),
      .rec_ready(rec_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .overrun(overrun));
   sfs_host_model u_host (.cs_n(cs_n), .sck(sck), .io0(io0), .io1(io1), .dev_out0(o0), .dev_oe0(e0),
      .dev_out1(o1), .dev_oe1(e1));

   // -----------------------------------------
   // Record and read byte handshakes
   // -----------------------------------------
   // Read data only changes once taken, so an offered byte stays stable
   always @(posedge clk) begin
      if (rec_valid === 1'b1 && rec_ready) got_q.push_back(rec_data);
      if (rd_valid && rd_ready === 1'b1) begin
         acc_q.push_back(rd_data);
         #1 rd_data = 8'($random(seed));
      end
   end
   always @(posedge clk) begin
      #1 rec_ready = stall ? 1'b0 : (($random(seed) & 3) != 0);
   end
   // Hang guard, well above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // -----------------------------------------
   // Checking helpers
   // -----------------------------------------
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, g, e);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Command shape: -1 unknown, 0 none, 1 write, 2 dual write, 3 read, 4 dual read
   function automatic int shape(input logic [7:0] op, output int ha, output int dm);
      ha = 1;
      dm = 0;
      case (op)
         8'h03: return 3;
         8'h0b: begin dm = 1; return 3; end
         8'h1b, 8'h77: begin dm = 2; return 3; end
         8'h3b: begin dm = 1; return 4; end
         8'h02: return 1;
         8'ha2: return 2;
         8'h20: return 0;
         8'h01: begin ha = 0; return 1; end
         8'h06: begin ha = 0; return 0; end
         default: return -1;
      endcase
   endfunction

   task automatic cmp_recs();
      sfs_word_t g, e;
      check(got_q.size(), exp_q.size());
      while (exp_q.size() != 0 && got_q.size() != 0) begin
         g = got_q.pop_front();
         e = exp_q.pop_front();
         check({g.is_cmd, g.opcode}, {e.is_cmd, e.opcode});
         check(e.is_cmd ? g.addr : g.data, e.is_cmd ? e.addr : e.data);
      end
      got_q.delete();
      exp_q.delete();
   endtask

   // One whole frame; cut stops it inside the address
   task automatic run_cmd(input bit m3, input logic [7:0] op, input logic [23:0] a, input int nd, input bit cut);
      int io, ha, dm;
      logic [7:0] r, b, e;
      io = shape(op, ha, dm);
      u_host.begin_frame(m3);
      u_host.xfer(op, 0, 8, r);
      if (io >= 3) @(posedge clk) #1 rd_valid = 1'b1;
      if (cut) begin
         u_host.xfer(a[23:16], 0, 8, r);
         u_host.xfer(a[15:8], 0, 3, r);
      end else if (io < 0) begin
         for (int k = 0; k < 3; k++) u_host.xfer(OP_WREN, 0, 8, r);
      end else begin
         if (ha != 0) for (int k = 2; k >= 0; k--) u_host.xfer(a[8*k +: 8], 0, 8, r);
         for (int k = 0; k < dm; k++) u_host.xfer(8'($random(seed)), 0, 8, r);
         exp_q.push_back('{is_cmd: 1'b1, opcode: op, addr: (ha != 0) ? a[19:0] : 20'h00000, data: 8'h00});
         for (int k = 0; k < nd; k++) begin
            b = $random(seed);
            if (io == 1 || io == 2) begin
               u_host.xfer(b, io - 1, 8, r);
               exp_q.push_back('{is_cmd: 1'b0, opcode: op, addr: 20'h00000, data: b});
            end else if (io >= 3) begin
               if (k == 0) check(acc_q.size() != 0, 1'b1);
               e = (acc_q.size() != 0) ? acc_q.pop_front() : TX_FILL;
               u_host.xfer(b, (io == 4) ? 2 : 0, 8, r);
               check(r, e);
            end
         end
      end
      @(posedge clk) #1 rd_valid = 1'b0;
      u_host.end_frame(m3);
      repeat (40) @(posedge clk);
      check({e0, e1}, 2'b00);
      check(u_host.saw_oe0, io == 4);
      acc_q.delete();
      if (!stall) cmp_recs();
   endtask

   // -----------------------------------------
   // Main sequence
   // -----------------------------------------
   initial begin
      logic [7:0] rops[5], wops[5], all[10];
      rops = '{8'h03, 8'h0b, 8'h1b, 8'h77, 8'h3b};
      wops = '{8'h02, 8'ha2, 8'h01, 8'h06, 8'h20};
      all = '{8'h03, 8'h0b, 8'h1b, 8'h77, 8'h3b, 8'h02, 8'ha2, 8'h01, 8'h06, 8'h20};
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (5) @(posedge clk);
      for (int m = 0; m < 2; m++)
         for (int i = 0; i < 5; i++) run_cmd(m, rops[i], 24'($random(seed)), 3, 0);
      $display("test reads done");
      for (int m = 0; m < 2; m++)
         for (int i = 0; i < 5; i++) run_cmd(m, wops[i], 24'($random(seed)), (i < 2) ? 3 : 1, 0);
      $display("test writes done");
      run_cmd(0, 8'h00, 24'h000000, 0, 0);
      run_cmd(1, 8'hff, 24'h000000, 0, 0);
      run_cmd(0, OP_PROG, 24'($random(seed)), 0, 1);
      run_cmd(1, OP_WREN, 24'h000000, 0, 0);
      $display("test refusals done");
      repeat (12) run_cmd($random(seed) & 1, all[$unsigned($random(seed)) % 10], 24'($random(seed)), 2, 0);
      $display("test random done");
      // Three records fit while stalled; five must overflow
      stall = 1'b1;
      run_cmd(0, OP_PROG, 24'hfabcde, 2, 0);
      check(overrun, 1'b0);
      stall = 1'b0;
      repeat (30) @(posedge clk);
      cmp_recs();
      stall = 1'b1;
      run_cmd(1, OP_PROG_DUAL, 24'h0fffff, 4, 0);
      check(overrun, 1'b1);
      stall = 1'b0;
      repeat (30) @(posedge clk);
      got_q.delete();
      exp_q.delete();
      @(posedge clk) #1 rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 check({overrun, rec_valid, rd_ready, e0, e1, o0, o1}, 7'h00);
      rst_n = 1'b1;
      repeat (5) @(posedge clk);
      run_cmd(0, OP_RD_FAST, 24'h12345a, 2, 0);
      $display("test buffer and reset done");
      end_of_test();
   end
endmodule
